// [ptsb_pkg.sv]
// ptsb_pkg: constants, field layouts and types for the tlp stream block.
// assumes a single 100 MHz user clock shared by every importing module.
package ptsb_pkg;

    // config-space window registers, byte offsets
    localparam int          PTSB_NWIN = 7;
    localparam logic [7:0]  PTSB_OFF_WIN [PTSB_NWIN] =
        '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
    localparam logic [31:0] PTSB_WIN_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        PTSB_WK_NONE, PTSB_WK_M32, PTSB_WK_M64LO, PTSB_WK_M64HI, PTSB_WK_IO, PTSB_WK_ROM
    } ptsb_wkind_e;

    // window 0/1 form one 64-bit memory window
    localparam ptsb_wkind_e PTSB_WIN_KIND [PTSB_NWIN] = '{PTSB_WK_M64LO, PTSB_WK_M64HI,
        PTSB_WK_M32, PTSB_WK_IO, PTSB_WK_NONE, PTSB_WK_NONE, PTSB_WK_ROM};
    localparam logic [31:0] PTSB_WIN_MASK [PTSB_NWIN] = '{32'hFFF0_0000, 32'hFFFF_FFFF,
        32'hFFFF_F000, 32'hFFFF_FF00, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_0001};
    localparam logic [31:0] PTSB_WIN_TYPE [PTSB_NWIN] = '{32'h0000_0004, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    localparam logic [31:0] PTSB_ROM_EN  = 32'h0000_0001;
    localparam int          PTSB_HIT_RSV = 7;

    // header fields and codes
    localparam logic [2:0] PTSB_FMT_3ND = 3'h0;
    localparam logic [2:0] PTSB_FMT_4ND = 3'h1;
    localparam logic [2:0] PTSB_FMT_3D  = 3'h2;
    localparam logic [4:0] PTSB_TY_MEM  = 5'h00;
    localparam logic [4:0] PTSB_TY_IO   = 5'h02;
    localparam logic [4:0] PTSB_TY_CFG0 = 5'h04;
    localparam logic [4:0] PTSB_TY_CPL  = 5'h0A;
    localparam logic [4:0] PTSB_TY_MSG  = 5'h10;
    localparam logic [2:0] PTSB_ST_SC   = 3'h0;
    localparam logic [2:0] PTSB_ST_UR   = 3'h1;
    localparam logic [7:0] PTSB_MSG_NF  = 8'h21;
    localparam logic [11:0] PTSB_CFG_BC = 12'h004;
    localparam logic [9:0] PTSB_LEN_1   = 10'h001;
    localparam logic [10:0] PTSB_LEN_MAX = 11'h400;
    localparam logic [10:0] PTSB_HDR3   = 11'h003;
    localparam logic [10:0] PTSB_HDR4   = 11'h004;
    localparam logic [10:0] PTSB_BEAT_DW = 11'h004;
    // completer id: arbitrary neutral value
    localparam logic [15:0] PTSB_CPL_ID = 16'h0100;

    localparam logic [15:0] PTSB_KEEP_4 = 16'hFFFF;
    localparam logic [15:0] PTSB_KEEP_3 = 16'h0FFF;
    localparam logic [15:0] PTSB_KEEP_2 = 16'h00FF;
    localparam logic [15:0] PTSB_KEEP_1 = 16'h000F;
    localparam int          PTSB_TUSER_W = 10;

    typedef struct packed {
        logic [2:0]  fmt;
        logic [4:0]  ty;
        logic [13:0] attr;
        logic [9:0]  len;
    } ptsb_dw0_s;

    // one quad_doubleword_beat plus its framing
    typedef struct packed {
        logic [127:0] data;
        logic [15:0]  keep;
        logic         last;
    } ptsb_beat_s;

    typedef enum logic [1:0] {PTSB_RX_IDLE, PTSB_RX_FWD, PTSB_RX_DROP} ptsb_rx_e;
    typedef enum logic [1:0] {PTSB_IK_CPL, PTSB_IK_CPLD, PTSB_IK_UR, PTSB_IK_MSG} ptsb_ik_e;

    // payload bytes go big-endian onto the doubleword
    function automatic logic [31:0] ptsb_bswap(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

endpackage

// [ptsb_win_decode.sv]
// ptsb_win_decode: compares a request address against the window bases.
// assumes bases are already masked by the register write logic.
`timescale 1ns/100ps
module ptsb_win_decode
    import ptsb_pkg::*;
(
    input  wire logic [31:0] base_i [PTSB_NWIN],
    input  wire logic [63:0] addr_i,
    input  wire logic        is_io_i,
    output logic      [7:0]  hit_o
);
    assign hit_o[PTSB_HIT_RSV] = 1'b0;

    for (genvar i = 0; i < PTSB_NWIN; i++)
    begin : g_win
        localparam int LO = (i > 0) ? i - 1 : 0;
        localparam int HI = (i < PTSB_NWIN - 1) ? i + 1 : i;
        logic h;
        // one driver per output bit, so each slice owns its result
        assign hit_o[i] = h;
        always_comb
        begin
            h = 1'b0;
            case (PTSB_WIN_KIND[i])
                PTSB_WK_M32: h = !is_io_i && addr_i[63:32] == 32'h0
                    && (base_i[i] & PTSB_WIN_MASK[i]) != 32'h0
                    && (addr_i[31:0] & PTSB_WIN_MASK[i]) == (base_i[i] & PTSB_WIN_MASK[i]);
                PTSB_WK_IO: h = is_io_i
                    && (base_i[i] & PTSB_WIN_MASK[i]) != 32'h0
                    && (addr_i[31:0] & PTSB_WIN_MASK[i]) == (base_i[i] & PTSB_WIN_MASK[i]);
                PTSB_WK_ROM: h = !is_io_i && base_i[i][0] && addr_i[63:32] == 32'h0
                    && (addr_i[31:0] & PTSB_WIN_MASK[i] & ~PTSB_ROM_EN)
                    == (base_i[i] & PTSB_WIN_MASK[i] & ~PTSB_ROM_EN);
                // lower half always hits for the pair [RL3]
                PTSB_WK_M64LO: h = !is_io_i && addr_i[63:32] == base_i[HI]
                    && {base_i[HI], base_i[i] & PTSB_WIN_MASK[i]} != 64'h0
                    && (addr_i[31:0] & PTSB_WIN_MASK[i]) == (base_i[i] & PTSB_WIN_MASK[i]);
                // upper bit only when a 64-bit address was given [RL5]
                PTSB_WK_M64HI: h = !is_io_i && base_i[i] != 32'h0
                    && addr_i[63:32] == base_i[i]
                    && (addr_i[31:0] & PTSB_WIN_MASK[LO]) == (base_i[LO] & PTSB_WIN_MASK[LO]);
                default: h = 1'b0;
            endcase
        end
    end
endmodule

// [ptsb_tlp_stream.sv]
// ptsb_tlp_stream: tlp stream block between the link core and user logic.
// assumes link-side streams and link_up_i are synchronous to clk_i.
`timescale 1ns/100ps
// What the document requires of this block and its user
// [RL1] root port mode: no window decode, no base/limit filtering
// [RL2] endpoint: decode memory/io requests, hit vector on tuser[9:2]
// [RL3] one hit bit for 32-bit windows, two adjacent for 64-bit
// [RL4] unmatched request dropped silently, device queues unsupported-request response
// [RL5] 64-bit window given only 32-bit address gives one hit bit
// [RL6] hit bits 0..5 windows at 10h..24h, bit 6 rom at 30h, 7 reserved
// [RL7] hit vector held for the whole memory/io packet from its first beat
// [RL8] link down is a hot reset, stored packets discarded
// [RL9] receive packet in flight still completes to its header length
// [RL10] user treats a packet cut by link down as corrupt
// [RL11] stream width and clock fixed regardless of lane count or speed
// [RL12] packets big-endian: byte 0 at bits 31:24 of first doubleword
// [RL13] header is three or four doublewords, from format and type
// [RL14] user sends only well-formed packets; no format check here
// [RL15] device answers config requests and flags bad inbound requests itself
// [RL16] user builds its own requests and completions
// [RL17] endpoint raises internal request while an own packet waits
// [RL18] grant held high: own packets first, user packets stalled
// [RL19] user may hold grant low, then must grant at least one cycle
// [RL20] user holds first beat until transmit ready
// [RL21] user sends remaining beats, last with keep matching length
// [RL22] user drops valid after the final beat
// [RL23] transmit ready low while sending a granted internal packet
// [RL24] beats move only when valid and ready are both high
module ptsb_tlp_stream
    import ptsb_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    root_port_i,
    input  wire logic                    link_up_i,
    input  wire ptsb_beat_s              link_rx_beat_i,
    input  wire logic                    link_rx_valid_i,
    output logic                         link_rx_ready_o,
    output ptsb_beat_s                   user_rx_beat_o,
    output logic [PTSB_TUSER_W-1:0]      user_rx_tuser_o,
    output logic                         user_rx_valid_o,
    input  wire logic                    user_rx_ready_i,
    input  wire ptsb_beat_s              user_tx_beat_i,
    input  wire logic                    user_tx_valid_i,
    output logic                         user_tx_ready_o,
    output ptsb_beat_s                   link_tx_beat_o,
    output logic                         link_tx_valid_o,
    input  wire logic                    link_tx_ready_i,
    output logic                         int_tlp_req_o,
    input  wire logic                    int_tlp_gnt_i,
    output logic                         user_link_up_o
);
    // stream width never depends on link width or speed [RL11]
    ptsb_rx_e    rx_st_q;
    logic [10:0] dw_left_q;
    logic        rx_rdy_q;
    logic        rx_v_q;
    ptsb_beat_s  rx_beat_q;
    logic [PTSB_TUSER_W-1:0] rx_user_q;
    logic [31:0] win_q [PTSB_NWIN];
    logic        pend_q;
    ptsb_ik_e    ik_q;
    logic [15:0] rid_q;
    logic [7:0]  tag_q;
    logic [31:0] cdata_q;
    logic        tx_v_q;
    ptsb_beat_s  tx_q;
    logic        utx_rdy_q;
    logic        inpkt_q;
    logic        req_q;
    logic        lnk_q;

    ptsb_dw0_s   h0;
    logic        hdr4;
    logic        is_mem;
    logic        is_io;
    logic        is_cfg;
    logic [10:0] pay;
    logic [10:0] total;
    logic [63:0] addr;
    logic [7:0]  dec_hit;
    logic [7:0]  hit_new;
    logic        beat_tk;
    logic        first_tk;
    logic        unclaimed;
    logic        fwd_new;
    logic        pad_beat;
    logic        load;
    logic        step;
    logic [10:0] dw_cur;
    logic        last_b;
    logic [15:0] keep_cur;
    logic        rx_v_d;
    logic        pend_d;
    logic [7:0]  cfg_off;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_wmask;
    logic [31:0] cfg_rdata;
    logic        cfg_wr;
    logic        utx_tk;
    logic        int_send;
    logic        tx_v_d;
    logic        inpkt_d;
    ptsb_beat_s  int_beat;

    // header decode on the first beat, byte 0 at bits 31:24 [RL12]
    assign h0      = link_rx_beat_i.data[31:0];
    assign hdr4    = h0.fmt[0]; // [RL13]
    assign is_mem  = h0.ty[4:1] == PTSB_TY_MEM[4:1];
    assign is_io   = h0.ty == PTSB_TY_IO;
    assign is_cfg  = h0.ty == PTSB_TY_CFG0;
    assign pay     = !h0.fmt[1] ? 11'h000 : (h0.len == 10'h000) ? PTSB_LEN_MAX : {1'b0, h0.len};
    assign total   = (hdr4 ? PTSB_HDR4 : PTSB_HDR3) + pay;
    assign addr    = hdr4 ? {link_rx_beat_i.data[95:64], link_rx_beat_i.data[127:96]}
                          : {32'h0, link_rx_beat_i.data[95:64]};

    ptsb_win_decode u_dec (
        .base_i  (win_q),
        .addr_i  (addr),
        .is_io_i (is_io),
        .hit_o   (dec_hit)
    );

    // root port passes all but type 0 config requests, with no hit bits [RL1] [RL2]
    assign hit_new   = (root_port_i || !(is_mem || is_io)) ? 8'h00 : dec_hit;
    assign unclaimed = !root_port_i && (is_mem || is_io) && dec_hit == 8'h00; // [RL4]
    assign fwd_new   = !is_cfg && !unclaimed; // [RL15]

    assign beat_tk  = link_rx_valid_i && rx_rdy_q; // [RL24]
    assign first_tk = beat_tk && rx_st_q == PTSB_RX_IDLE;
    // padding runs after link loss so the user sees the full length [RL9]
    assign pad_beat = rx_st_q == PTSB_RX_FWD && !link_up_i && !rx_v_q && !beat_tk;
    assign load     = (beat_tk && (rx_st_q == PTSB_RX_FWD || (first_tk && fwd_new))) || pad_beat;
    assign step     = first_tk || (rx_st_q == PTSB_RX_FWD && load)
                      || (rx_st_q == PTSB_RX_DROP && beat_tk);
    assign dw_cur   = first_tk ? total : dw_left_q;
    assign last_b   = dw_cur <= PTSB_BEAT_DW;

    always_comb
    begin
        case (dw_cur[1:0])
            2'd3:    keep_cur = PTSB_KEEP_3;
            2'd2:    keep_cur = PTSB_KEEP_2;
            2'd1:    keep_cur = PTSB_KEEP_1;
            default: keep_cur = PTSB_KEEP_4;
        endcase
        if (!last_b)
            keep_cur = PTSB_KEEP_4;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_st_q   <= PTSB_RX_IDLE;
            dw_left_q <= 11'h000;
        end
        else if (rx_st_q == PTSB_RX_DROP && !link_up_i)
            rx_st_q <= PTSB_RX_IDLE;
        else if (step)
        begin
            dw_left_q <= dw_cur - PTSB_BEAT_DW;
            if (last_b)
                rx_st_q <= PTSB_RX_IDLE;
            else if (first_tk)
                rx_st_q <= fwd_new ? PTSB_RX_FWD : PTSB_RX_DROP;
        end
    end

    assign rx_v_d = load || (rx_v_q && !user_rx_ready_i);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rx_v_q    <= 1'b0;
            rx_beat_q <= '0;
            rx_user_q <= '0;
        end
        else
        begin
            rx_v_q <= rx_v_d;
            if (load)
            begin
                // pad beats carry zero data; the user treats the cut packet as corrupt [RL10]
                rx_beat_q.data <= pad_beat ? 128'h0 : link_rx_beat_i.data;
                rx_beat_q.keep <= keep_cur;
                rx_beat_q.last <= last_b;
            end
            if (first_tk && fwd_new)
                rx_user_q <= {hit_new, 2'b00}; // [RL2] [RL7]
        end
    end

    // one output slot keeps ready a flop, at half throughput
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rx_rdy_q <= 1'b0;
        else
            rx_rdy_q <= link_up_i && ((rx_st_q == PTSB_RX_DROP && !(step && last_b))
                        || (!rx_v_d && !(pend_d && (rx_st_q == PTSB_RX_IDLE
                        || (step && last_b)))));
    end

    // window registers, written by type 0 config writes
    assign cfg_off   = {link_rx_beat_i.data[71:66], 2'b00};
    assign cfg_wdata = ptsb_bswap(link_rx_beat_i.data[127:96]);
    assign cfg_wmask = {{8{link_rx_beat_i.data[35]}}, {8{link_rx_beat_i.data[34]}},
                        {8{link_rx_beat_i.data[33]}}, {8{link_rx_beat_i.data[32]}}};
    assign cfg_wr    = first_tk && is_cfg && h0.fmt == PTSB_FMT_3D; // [RL15]

    for (genvar i = 0; i < PTSB_NWIN; i++)
    begin : g_reg
        always_ff @(posedge clk_i)
        begin
            // hot reset clears the windows [RL8]
            if (sys_rst_i || !link_up_i)
                win_q[i] <= PTSB_WIN_RST;
            else if (cfg_wr && cfg_off == PTSB_OFF_WIN[i]) // [RL6]
                win_q[i] <= (win_q[i] & ~cfg_wmask)
                            | (cfg_wdata & cfg_wmask & PTSB_WIN_MASK[i]);
        end
    end

    always_comb
    begin
        cfg_rdata = 32'h0;
        for (int i = 0; i < PTSB_NWIN; i++)
            if (cfg_off == PTSB_OFF_WIN[i])
                cfg_rdata = (win_q[i] & PTSB_WIN_MASK[i]) | PTSB_WIN_TYPE[i];
    end

    // single internal packet slot; a full slot stalls new receive packets
    assign pend_d = link_up_i && ((first_tk && (is_cfg || unclaimed)) || (pend_q && !int_send));

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pend_q  <= 1'b0;
            ik_q    <= PTSB_IK_CPL;
            rid_q   <= 16'h0;
            tag_q   <= 8'h0;
            cdata_q <= 32'h0;
        end
        else
        begin
            pend_q <= pend_d; // [RL8]
            if (first_tk && (is_cfg || unclaimed))
            begin
                rid_q   <= link_rx_beat_i.data[63:48];
                tag_q   <= link_rx_beat_i.data[47:40];
                cdata_q <= ptsb_bswap(cfg_rdata);
                if (is_cfg)
                    ik_q <= h0.fmt[1] ? PTSB_IK_CPL : PTSB_IK_CPLD; // [RL15]
                else
                    ik_q <= (h0.fmt[1] && !is_io) ? PTSB_IK_MSG : PTSB_IK_UR; // [RL4]
            end
        end
    end

    always_comb
    begin
        int_beat      = '0;
        int_beat.last = 1'b1;
        int_beat.keep = PTSB_KEEP_3;
        int_beat.data[28:24] = PTSB_TY_CPL;
        int_beat.data[63:48] = PTSB_CPL_ID;
        int_beat.data[43:32] = PTSB_CFG_BC;
        int_beat.data[95:72] = {rid_q, tag_q};
        case (ik_q)
            PTSB_IK_CPLD:
            begin
                int_beat.data[31:29]  = PTSB_FMT_3D;
                int_beat.data[9:0]    = PTSB_LEN_1;
                int_beat.data[127:96] = cdata_q;
                int_beat.keep         = PTSB_KEEP_4;
            end
            PTSB_IK_UR:
                int_beat.data[47:45] = PTSB_ST_UR;
            PTSB_IK_MSG:
            begin
                int_beat.data        = '0;
                int_beat.data[31:29] = PTSB_FMT_4ND;
                int_beat.data[28:24] = PTSB_TY_MSG;
                int_beat.data[63:48] = PTSB_CPL_ID;
                int_beat.data[39:32] = PTSB_MSG_NF;
                int_beat.keep        = PTSB_KEEP_4;
            end
            default:
                int_beat.data[47:45] = PTSB_ST_SC;
        endcase
    end

    // transmit arbitration and output register
    assign utx_tk   = user_tx_valid_i && utx_rdy_q; // [RL24] [RL20]
    assign int_send = pend_q && int_tlp_gnt_i && !utx_rdy_q && !inpkt_q && link_up_i
                      && (!tx_v_q || link_tx_ready_i); // [RL18]
    assign tx_v_d   = link_up_i && (utx_tk || int_send || (tx_v_q && !link_tx_ready_i));
    assign inpkt_d  = link_up_i && (utx_tk ? !user_tx_beat_i.last : inpkt_q); // [RL21]

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tx_v_q    <= 1'b0;
            tx_q      <= '0;
            utx_rdy_q <= 1'b0;
            inpkt_q   <= 1'b0;
        end
        else
        begin
            tx_v_q  <= tx_v_d; // [RL8]
            inpkt_q <= inpkt_d;
            // user beats pass unchecked [RL14]
            if (utx_tk)
                tx_q <= user_tx_beat_i;
            else if (int_send)
                tx_q <= int_beat;
            // ready drops while an internal packet is granted or in flight [RL23]
            utx_rdy_q <= link_up_i && !tx_v_d && !(pend_d && int_tlp_gnt_i && !inpkt_d);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            req_q <= 1'b0;
            lnk_q <= 1'b0;
        end
        else
        begin
            req_q <= pend_d; // [RL17]
            lnk_q <= link_up_i;
        end
    end

    assign link_rx_ready_o = rx_rdy_q;
    assign user_rx_beat_o  = rx_beat_q;
    assign user_rx_tuser_o = rx_user_q;
    assign user_rx_valid_o = rx_v_q;
    assign user_tx_ready_o = utx_rdy_q;
    assign link_tx_beat_o  = tx_q;
    assign link_tx_valid_o = tx_v_q;
    assign int_tlp_req_o   = req_q;
    assign user_link_up_o  = lnk_q;

    a_root_no_hit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL1]
        first_tk && fwd_new && root_port_i |=> user_rx_tuser_o == '0)
        else $error("root port mode produced a hit bit");
    a_hit_shape: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL3]
        user_rx_valid_o |-> $countones(user_rx_tuser_o) <= 2 && !user_rx_tuser_o[9])
        else $error("hit vector has too many bits or reserved bit");
    a_drop_unclaimed: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL4]
        first_tk && unclaimed && link_up_i |=> pend_q && !user_rx_valid_o
        && (ik_q == PTSB_IK_UR || ik_q == PTSB_IK_MSG))
        else $error("unclaimed request not dropped with error response");
    a_hit_held: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL7]
        user_rx_valid_o && user_rx_ready_i && !user_rx_beat_o.last
        |=> $stable(user_rx_tuser_o))
        else $error("hit vector changed inside a packet");
    a_hot_flush: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL8]
        !link_up_i |=> !int_tlp_req_o && !link_tx_valid_o && !user_tx_ready_o)
        else $error("link down did not flush internal state");
    a_pad_emit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL9]
        pad_beat |=> user_rx_valid_o && user_rx_beat_o.data == 128'h0)
        else $error("missing pad beat after link loss");
    a_req_raise: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL17]
        first_tk && is_cfg && link_up_i |=> int_tlp_req_o)
        else $error("internal request not raised for config access");
    a_user_stall: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL18]
        int_tlp_req_o && int_tlp_gnt_i && !inpkt_q && !user_tx_ready_o
        |=> !user_tx_ready_o)
        else $error("user allowed while internal packet pending");
    a_int_send: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL23]
        int_send |=> link_tx_valid_o && link_tx_beat_o.last && !user_tx_ready_o)
        else $error("internal packet send misbehaved");
    a_tx_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RL24]
        user_tx_valid_i && user_tx_ready_o && link_up_i
        |=> link_tx_valid_o && link_tx_beat_o == $past(user_tx_beat_i))
        else $error("accepted user beat not forwarded");
endmodule

// [ptsb_user_model.sv]
// ptsb_user_model: user-side receive sink facing the tlp stream block.
// assumes user_rx outputs change only on rising edges of clk_i.
`timescale 1ns/100ps
module ptsb_user_model
    import ptsb_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [3:0] stall_i,
    input  wire ptsb_beat_s beat_i,
    input  wire logic [9:0] tuser_i,
    input  wire logic       valid_i,
    output logic            ready_o,
    output ptsb_beat_s      got_beat_o,
    output logic [9:0]      got_tuser_o,
    output logic [7:0]      got_n_o
);
    logic [3:0] wait_q = 4'h0;
    logic       rdy_q  = 1'b0;
    logic [7:0] n_q    = 8'h00;
    assign ready_o = rdy_q;
    assign got_n_o = n_q;
    // slow consumer: ready held back stall_i cycles so the hit vector must stand
    // valid never drops untaken, so a ready seen at an edge was a transfer
    always @(negedge clk_i)
    begin
        if (rdy_q)
        begin
            wait_q <= 4'h0;
            rdy_q  <= 1'b0;
        end
        else
        begin
            if (valid_i && wait_q != stall_i)
                wait_q <= wait_q + 4'h1;
            rdy_q <= valid_i && wait_q == stall_i;
        end
    end
    // last beat, its tuser and a beat count are kept; pad beats of a cut packet are counted like any other
    always @(posedge clk_i)
    begin
        if (valid_i && rdy_q)
        begin
            got_beat_o  <= beat_i;
            got_tuser_o <= tuser_i;
            n_q         <= n_q + 8'h01;
        end
    end
endmodule

// [ptsb_tlp_stream_tb.sv]
// ptsb_tlp_stream_tb: sequences of config, receive and transmit packets.
// assumes the bench plays the link core; the user model sinks receive.
`timescale 1ns/100ps
module ptsb_tlp_stream_tb import ptsb_pkg::*;;
    logic clk = 0, rst = 1, lup = 1, rxv = 0, txv = 0, ltrdy = 0, gnt = 1, rp = 0;
    logic lrrdy, urv, urr, utr, ltv, req, ulu;
    ptsb_beat_s rxb = '0, txb = '0, urxb, ltxb, gb, ub;
    logic [9:0] tu, gtu;
    logic [7:0] gn, n0;
    int errors = 0, n_checks = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    ptsb_tlp_stream dut_u (.clk_i(clk), .sys_rst_i(rst), .root_port_i(rp),
        .link_up_i(lup), .link_rx_beat_i(rxb), .link_rx_valid_i(rxv),
        .link_rx_ready_o(lrrdy), .user_rx_beat_o(urxb), .user_rx_tuser_o(tu),
        .user_rx_valid_o(urv), .user_rx_ready_i(urr), .user_tx_beat_i(txb),
        .user_tx_valid_i(txv), .user_tx_ready_o(utr), .link_tx_beat_o(ltxb),
        .link_tx_valid_o(ltv), .link_tx_ready_i(ltrdy), .int_tlp_req_o(req),
        .int_tlp_gnt_i(gnt), .user_link_up_o(ulu));
    ptsb_user_model user_u (.clk_i(clk), .stall_i(4'h3), .beat_i(urxb), .tuser_i(tu),
        .valid_i(urv), .ready_o(urr), .got_beat_o(ub), .got_tuser_o(gtu), .got_n_o(gn));
    function automatic logic [31:0] sw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    task automatic chk(input string what, input logic [159:0] e, input logic [159:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // beat held until the edge that samples ready high
    task automatic rx_send(input logic [127:0] d);
        @(negedge clk);
        rxb = {d, 16'hFFFF, 1'b1};
        rxv = 1;
        repeat (50)
        begin
            if (lrrdy === 1'b1)
                break;
            @(negedge clk);
        end
        @(negedge clk);
        rxv = 0;
    endtask
    task automatic tx_get(output ptsb_beat_s b);
        repeat (50)
        begin
            @(negedge clk);
            if (ltv === 1'b1)
                break;
        end
        chk("tx ready", 1'b0, utr);
        b = ltxb;
        ltrdy = 1;
        @(negedge clk);
        ltrdy = 0;
    endtask
    task automatic cfgw(input logic [7:0] off, input logic [31:0] v);
        rx_send({sw(v), 24'h0, off, 32'h0000000F, 32'h44000001});
        tx_get(gb);
        chk("cpl hdr", {16'h0FFF, 8'h0A}, {gb.keep, gb.data[31:24]});
    endtask
    task automatic cfgr(input logic [7:0] off, input logic [31:0] v);
        rx_send({32'h0, 24'h0, off, 32'h0000000F, 32'h04000001});
        tx_get(gb);
        chk("cpld", {16'hFFFF, 8'h4A, sw(v)}, {gb.keep, gb.data[31:24], gb.data[127:96]});
    endtask
    task automatic rxchk(input logic [127:0] d, input logic [9:0] e);
        n0 = gn;
        rx_send(d);
        repeat (20) @(negedge clk);
        chk("rx count", n0 + 8'h01, gn);
        chk("rx beat", {d, 16'hFFFF, 1'b1}, ub);
        chk("rx hit", e, gtu);
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        cfgw(8'h18, 32'h12345678);
        cfgr(8'h18, 32'h12345000);
        gnt = 0;
        rx_send({32'h0, 32'h00000030, 32'h0000000F, 32'h04000001});
        repeat (4) @(negedge clk);
        chk("int req", 1'b1, req);
        chk("tx held", 1'b0, ltv);
        gnt = 1;
        tx_get(gb);
        chk("rom read", 32'h0, gb.data[127:96]);
        chk("req done", 1'b0, req);
        $display("test config done");
        rxchk({32'hA5A5A5A5, 32'h12345010, 32'h0000000F, 32'h40000001}, 10'h010);
        cfgw(8'h10, 32'h80000000);
        rxchk({32'hA5A5A5A5, 32'h80000100, 32'h0000000F, 32'h40000001}, 10'h004);
        cfgw(8'h14, 32'h00000001);
        rxchk({32'h80000100, 32'h00000001, 32'h0000000F, 32'h20000001}, 10'h00C);
        n0 = gn;
        rx_send({32'h0, 32'h00000200, 32'h0000000F, 32'h40000001});
        tx_get(gb);
        chk("msg", {16'hFFFF, 8'h21}, {gb.keep, gb.data[39:32]});
        // give a wrongly forwarded beat time to reach the slow sink
        repeat (10) @(negedge clk);
        chk("dropped", n0, gn);
        rp = 1;
        rxchk({32'hA5A5A5A5, 32'h00000200, 32'h0000000F, 32'h40000001}, 10'h000);
        rp = 0;
        $display("test decode done");
        @(negedge clk);
        txb = {128'hFEDCBA98_76543210_0000000F_40000001, 16'hFFFF, 1'b1};
        txv = 1;
        repeat (20)
        begin
            if (utr === 1'b1)
                break;
            @(negedge clk);
        end
        @(negedge clk);
        txv = 0;
        tx_get(gb);
        chk("tx beat", txb, gb);
        $display("test transmit done");
        // three-beat write cut after its first beat; the rest comes as padding
        n0 = gn;
        rx_send({32'h0, 32'h12345020, 32'h0000000F, 32'h40000008});
        lup = 0;
        repeat (3) @(negedge clk);
        chk("link up", 1'b0, ulu);
        repeat (40) @(negedge clk);
        chk("pad count", n0 + 8'h03, gn);
        chk("pad beat", {128'h0, 16'h0FFF, 1'b1}, ub);
        chk("pad hit", 10'h010, gtu);
        lup = 1;
        repeat (3) @(negedge clk);
        chk("link back", 1'b1, ulu);
        cfgr(8'h18, 32'h0);
        $display("test link down done");
        report_and_stop();
    end
endmodule
